// ==== verilog/overlay_readback_error_cursor_cmds.sv ====
// command interpreter: overlay window, readback, errors, cross hair
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ovl_cmd_map.svh"
module overlay_readback_error_cursor_cmds (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // decoded command stream
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire ovl_cmd_pkg::op_e   cmd_op,
  input  wire logic [2:0]         cmd_nparam,
  input  wire logic [3:0]         cmd_err,
  input  wire logic [15:0]        cmd_p0,
  input  wire logic [15:0]        cmd_p1,
  input  wire logic [15:0]        cmd_p2,
  input  wire logic [15:0]        cmd_p3,
  input  wire logic [15:0]        cmd_p4,
  input  wire logic [15:0]        cmd_p5,
  // readback and error fifo write ports
  input  wire logic               rb_full,
  output logic                    rb_wr,
  output logic      [7:0]         rb_data,
  input  wire logic               err_full,
  output logic                    err_wr,
  output logic      [7:0]         err_data,
  // complement draw requests to the drawing engine
  output logic                    draw_valid,
  input  wire logic               draw_ready,
  output ovl_cmd_pkg::shape_e     draw_shape,
  output logic      [15:0]        draw_x0,
  output logic      [15:0]        draw_y0,
  output logic      [15:0]        draw_x1,
  output logic      [15:0]        draw_y1,
  output logic                    draw_clip_view,
  // overlay window placement
  output logic      [15:0]        ovl_x0,
  output logic      [15:0]        ovl_x1,
  output logic      [15:0]        ovl_y0,
  output logic      [15:0]        ovl_y1,
  output logic      [15:0]        ovl_col,
  output logic      [15:0]        ovl_row,
  // video compose
  input  wire logic [7:0]         gfx_pixel,
  input  wire logic [7:0]         emu_pixel,
  input  wire logic               in_window,
  input  wire logic               glyph_bit,
  input  wire logic               blink_attr,
  input  wire logic               blink_phase,
  input  wire logic               cursor_here,
  output logic      [7:0]         monitor_pixel
);
  import ovl_cmd_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  st_e         state;
  logic [2:0]  ctrl;
  logic        ovl_vis, full_emu;
  logic [7:0]  ovl_colour;
  logic [2:0]  xh_flag;
  logic [15:0] xh_w, xh_h, pos_x, pos_y, anc_x, anc_y;
  logic [1:0]  band_mode;
  // shapes now on screen, erased by complementing again
  logic        sh_xh_on, sh_band_on, sh_band_rect, sh_xh_view;
  logic [15:0] sh_xh_x, sh_xh_y, sh_xh_w, sh_xh_h;
  logic [15:0] sh_ax, sh_ay, sh_bx, sh_by;
  logic [3:0]  pend;
  logic [3:0]  err_code;
  logic [3:0]  str_idx;
  logic        rb_sel;
  logic [15:0] rb_val;
  logic [2:0]  dig_idx;
  logic        dig_seen;

  wire hex_mode = ctrl[`CTRL_HEX];
  wire take     = cmd_valid && cmd_ready;
  wire xh_on    = xh_flag != 3'h0;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [63:0] err_text(input logic [3:0] c);
    case (c)
      `ERR_RANGE:    err_text = "Range";
      `ERR_INTEGER:  err_text = "Integer";
      `ERR_MEMORY:   err_text = "Memory";
      `ERR_OVERFLOW: err_text = "Overflow";
      `ERR_DIGIT:    err_text = "Digit";
      `ERR_OPCODE:   err_text = "Opcode";
      `ERR_RUNNING:  err_text = "Running";
      `ERR_STACK:    err_text = "Stack";
      `ERR_TOO_LONG: err_text = "Too long";
      `ERR_AREA:     err_text = "Area";
      default:       err_text = "Missing";
    endcase
  endfunction

  function automatic logic [15:0] pow10(input logic [2:0] i);
    case (i)
      3'h0:    pow10 = 16'h2710;
      3'h1:    pow10 = 16'h03e8;
      3'h2:    pow10 = 16'h0064;
      3'h3:    pow10 = 16'h000a;
      default: pow10 = 16'h0001;
    endcase
  endfunction

  function automatic logic [2:0] need(input op_e o, input logic [15:0] f);
    case (o)
      overlay_position_cmd: need = 3'h6;
      overlay_colour_cmd:   need = 3'h3;
      crosshair_move_cmd:   need = 3'h2;
      crosshair_enable_cmd: need = (f == 16'h1 || f == 16'h3) ? 3'h3 : 3'h1;
      readback_cmd:         need = 3'h0;
      other_cmd:            need = 3'h0;
      unknown_cmd:          need = 3'h0;
      default:              need = 3'h1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // command check
  // ---------------------------------------------------------------
  logic [3:0] next_err;
  always_comb begin
    next_err = cmd_err;
    if (next_err == `ERR_NONE) begin
      if (cmd_op == unknown_cmd)
        next_err = `ERR_OPCODE;
      else if (!hex_mode && cmd_nparam < need(cmd_op, cmd_p0))
        next_err = `ERR_MISSING;
      else if (cmd_op == crosshair_enable_cmd && cmd_p0 > {8'h0, `XH_FLAG_MAX})
        next_err = `ERR_RANGE;
      else if (cmd_op == rubber_band_cmd && cmd_p0 > {8'h0, `RB_FLAG_MAX})
        next_err = `ERR_RANGE;
    end
    if (hex_mode && (next_err == `ERR_INTEGER || next_err == `ERR_DIGIT ||
        next_err == `ERR_MISSING))
      next_err = `ERR_NONE;
  end

  // ---------------------------------------------------------------
  // sequencer: one command at a time
  // ---------------------------------------------------------------
  assign cmd_ready = (state == st_idle);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (take && next_err != `ERR_NONE)
            state <= ctrl[`CTRL_ERR_EN] ? st_err : st_idle;
          else if (take && cmd_op == readback_cmd)
            state <= st_rb;
          else if (take && (cmd_op == crosshair_enable_cmd ||
                   cmd_op == crosshair_move_cmd || cmd_op == rubber_band_cmd))
            state <= st_draw;
        end
        // leave only once the closing byte has gone out
        st_err: if (err_wr && (hex_mode || err_data == `CHAR_CR))
          state <= st_idle;
        st_rb: if (rb_wr && rb_sel && (hex_mode ? dig_idx == `RB_HEX_BYTES :
                   dig_idx == 3'h0 && rb_data == `CHAR_CR)) state <= st_idle;
        st_draw: if (pend == 4'h0 && !draw_valid) state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // overlay and display settings
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovl_vis <= 1'b0;
      full_emu <= 1'b0;
      ovl_colour <= 8'h0f;
      {ovl_x0, ovl_x1, ovl_y0, ovl_y1, ovl_col, ovl_row} <= '0;
    end else if (take && next_err == `ERR_NONE) begin
      case (cmd_op)
        overlay_position_cmd: begin
          // pixels, origin lower left; cells, origin upper left
          ovl_x0 <= cmd_p0;
          ovl_x1 <= cmd_p1;
          ovl_y0 <= cmd_p2;
          ovl_y1 <= cmd_p3;
          ovl_col <= cmd_p4;
          ovl_row <= ctrl[`CTRL_EMU40] ? {cmd_p5[14:0], 1'b0} : cmd_p5;
        end
        overlay_visibility_cmd: ovl_vis <= cmd_p0[0];
        overlay_colour_cmd: ovl_colour <= cmd_p0[7:0];
        full_screen_select_cmd: full_emu <= cmd_p0[0];
        default: ;
      endcase
    end
  end

  // overlay is composed on the way out, memory untouched
  wire fg_on = (glyph_bit && !(blink_attr && blink_phase)) ||
               (cursor_here && !blink_phase);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      monitor_pixel <= 8'h00;
    else if (full_emu)
      monitor_pixel <= emu_pixel;
    else if (ovl_vis && in_window && fg_on)
      monitor_pixel <= ovl_colour;
    else
      monitor_pixel <= gfx_pixel;
  end

  // ---------------------------------------------------------------
  // cross hair and rubber band state, screen space
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xh_flag <= 3'h0;
      {xh_w, xh_h, pos_x, pos_y, anc_x, anc_y} <= '0;
      band_mode <= 2'h0;
      pend <= 4'h0;
    end else if (take && next_err == `ERR_NONE) begin
      case (cmd_op)
        crosshair_enable_cmd: begin
          xh_flag <= cmd_p0[2:0];
          if (cmd_p0[2:0] == 3'h2 || cmd_p0[2:0] == 3'h4) begin
            xh_w <= `XH_FIXED;
            xh_h <= `XH_FIXED;
          end else if (cmd_p0[0]) begin
            xh_w <= cmd_p1;
            xh_h <= cmd_p2;
          end
          pend <= {cmd_p0[2:0] != 3'h0, 2'b00, sh_xh_on};
        end
        crosshair_move_cmd: begin
          pos_x <= cmd_p0;
          pos_y <= cmd_p1;
          pend <= {xh_on, band_mode != 2'h0, sh_band_on, sh_xh_on};
        end
        rubber_band_cmd: begin
          band_mode <= cmd_p0[1:0];
          anc_x <= pos_x;
          anc_y <= pos_y;
          pend <= {3'b000, 1'b0} | {2'b00, sh_band_on, 1'b0};
        end
        default: ;
      endcase
    end else if (state == st_draw && (!draw_valid || draw_ready)) begin
      // retire the lowest pending step as it is issued
      if (pend[0]) pend[0] <= 1'b0;
      else if (pend[1]) pend[1] <= 1'b0;
      else if (pend[2]) pend[2] <= 1'b0;
      else pend[3] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // draw issue: erase old, then draw new, all by complement
  // ---------------------------------------------------------------
  wire issue = state == st_draw && pend != 4'h0 && (!draw_valid || draw_ready);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      draw_valid <= 1'b0;
      draw_shape <= shp_line;
      {draw_x0, draw_y0, draw_x1, draw_y1} <= '0;
      draw_clip_view <= 1'b0;
      {sh_xh_on, sh_band_on, sh_band_rect, sh_xh_view} <= '0;
      {sh_xh_x, sh_xh_y, sh_xh_w, sh_xh_h} <= '0;
      {sh_ax, sh_ay, sh_bx, sh_by} <= '0;
    end else if (issue) begin
      draw_valid <= 1'b1;
      if (pend[0] || pend[2:1] == 2'b00) begin // same order as retire
        draw_shape <= shp_cross;
        draw_clip_view <= pend[0] ? sh_xh_view : xh_flag[2] || xh_flag == 3'h3;
        draw_x0 <= pend[0] ? sh_xh_x : pos_x;
        draw_y0 <= pend[0] ? sh_xh_y : pos_y;
        draw_x1 <= pend[0] ? sh_xh_w : xh_w;
        draw_y1 <= pend[0] ? sh_xh_h : xh_h;
        sh_xh_on <= !pend[0];
        if (!pend[0]) begin
          {sh_xh_x, sh_xh_y, sh_xh_w, sh_xh_h} <= {pos_x, pos_y, xh_w, xh_h};
          sh_xh_view <= xh_flag[2] || xh_flag == 3'h3;
        end
      end else if (pend[1]) begin
        draw_shape <= sh_band_rect ? shp_rect : shp_line;
        draw_clip_view <= 1'b0;
        {draw_x0, draw_y0, draw_x1, draw_y1} <= {sh_ax, sh_ay, sh_bx, sh_by};
        sh_band_on <= 1'b0;
      end else begin
        draw_shape <= band_mode[1] ? shp_rect : shp_line;
        draw_clip_view <= 1'b0;
        {draw_x0, draw_y0, draw_x1, draw_y1} <= {anc_x, anc_y, pos_x, pos_y};
        {sh_ax, sh_ay, sh_bx, sh_by} <= {anc_x, anc_y, pos_x, pos_y};
        sh_band_on <= 1'b1;
        sh_band_rect <= band_mode[1];
      end
    end else if (draw_ready) begin
      draw_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // error report into the error fifo
  // ---------------------------------------------------------------
  wire [63:0] etxt = err_text(err_code);
  wire [7:0]  echr = etxt[8'd63 - {str_idx[2:0], 3'b000} -: 8];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_code <= `ERR_NONE;
      str_idx <= 4'h0;
      err_wr <= 1'b0;
      err_data <= 8'h00;
    end else begin
      err_wr <= 1'b0;
      if (state == st_idle && take) begin
        err_code <= next_err;
        str_idx <= 4'h0;
      end else if (state == st_err && !err_full && !err_wr) begin
        if (hex_mode) begin
          err_wr <= 1'b1;
          err_data <= {4'h0, err_code};
        end else if (str_idx == `STR_END) begin
          err_wr <= 1'b1;
          err_data <= `CHAR_CR;
        end else begin
          err_wr <= echr != 8'h00; // leading pad bytes skipped
          err_data <= echr;
          str_idx <= str_idx + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // readback of the cross hair position into the readback fifo
  // ---------------------------------------------------------------
  wire [15:0] pw    = pow10(dig_idx);
  wire [15:0] digit = rb_val / pw;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_sel <= 1'b0;
      rb_val <= 16'h0;
      dig_idx <= 3'h0;
      dig_seen <= 1'b0;
      rb_wr <= 1'b0;
      rb_data <= 8'h00;
    end else begin
      rb_wr <= 1'b0;
      if (state == st_idle && take) begin
        rb_sel <= 1'b0;
        rb_val <= pos_x;
        dig_idx <= 3'h0;
        dig_seen <= 1'b0;
      end else if (state == st_rb && !rb_full && !rb_wr) begin
        if (hex_mode) begin
          rb_wr <= 1'b1;
          rb_data <= dig_seen ? rb_val[7:0] : rb_val[15:8];
          dig_seen <= !dig_seen;
          dig_idx <= dig_idx + 3'h1; // bytes sent so far
          if (dig_seen) begin
            rb_sel <= 1'b1;
            rb_val <= pos_y;
          end
        end else if (dig_idx > `DIGITS_LAST) begin
          rb_wr <= 1'b1;
          rb_data <= rb_sel ? `CHAR_CR : `CHAR_COMMA;
          dig_idx <= rb_sel ? 3'h0 : 3'h0;
          dig_seen <= 1'b0;
          if (!rb_sel) begin
            rb_sel <= 1'b1;
            rb_val <= pos_y;
          end
        end else begin
          rb_wr <= digit != 16'h0 || dig_seen || dig_idx == `DIGITS_LAST;
          rb_data <= `CHAR_ZERO + digit[7:0];
          dig_seen <= dig_seen || digit != 16'h0;
          rb_val <= rb_val % pw;
          dig_idx <= dig_idx + 3'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register port, read data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      ctrl <= `CTRL_RST;
    else if (reg_wr && reg_addr == `REG_CTRL)
      ctrl <= reg_wdata[2:0];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:   reg_rdata <= {29'h0, ctrl};
        `REG_STATUS: reg_rdata <= {20'h0, band_mode, xh_flag, full_emu,
                                   ovl_vis, state != st_idle, 4'h0};
        `REG_XPOS:   reg_rdata <= {pos_y, pos_x};
        `REG_ANCHOR: reg_rdata <= {anc_y, anc_x};
        default:     reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_move_taken;
    take && cmd_op == crosshair_move_cmd && next_err == `ERR_NONE;
  endsequence
  property p_move_pos;
    s_move_taken |=> pos_x == $past(cmd_p0) && pos_y == $past(cmd_p1);
  endproperty
  a_move_pos: assert property (p_move_pos) else $error("move lost");
  property p_in_order;
    draw_valid || rb_wr || err_wr |-> !cmd_ready;
  endproperty
  a_in_order: assert property (p_in_order) else $error("overlap");
  property p_rb_full;
    rb_full && !rb_wr |=> !rb_wr;
  endproperty
  a_rb_full: assert property (p_rb_full) else $error("rb overrun");
  property p_err_full;
    err_full && !err_wr |=> !err_wr;
  endproperty
  a_err_full: assert property (p_err_full) else $error("err overrun");
  property p_err_en;
    take && !ctrl[`CTRL_ERR_EN] |=> state != st_err;
  endproperty
  a_err_en: assert property (p_err_en) else $error("err when off");
  property p_hex_codes;
    err_wr && hex_mode |-> err_data != 8'h02 && err_data != 8'h05 &&
                           err_data != 8'h0b;
  endproperty
  a_hex_codes: assert property (p_hex_codes) else $error("hex code");
  property p_full_sel;
    full_emu ##1 full_emu |-> monitor_pixel == $past(emu_pixel);
  endproperty
  a_full_sel: assert property (p_full_sel) else $error("screen sel");
  property p_row40;
    take && cmd_op == overlay_position_cmd && next_err == `ERR_NONE &&
    ctrl[`CTRL_EMU40] |=> ovl_row == {$past(cmd_p5[14:0]), 1'b0};
  endproperty
  a_row40: assert property (p_row40) else $error("row map");
  property p_hidden;
    rst_n && !full_emu && !ovl_vis ##1 1'b1 |->
      monitor_pixel == $past(gfx_pixel);
  endproperty
  a_hidden: assert property (p_hidden) else $error("overlay shown");
  property p_anchor;
    take && cmd_op == rubber_band_cmd && next_err == `ERR_NONE |=>
      anc_x == $past(pos_x) && anc_y == $past(pos_y);
  endproperty
  a_anchor: assert property (p_anchor) else $error("anchor");
endmodule
`default_nettype wire

// ==== verilog/ovl_cmd_map.svh ====
// offsets, field positions, codes and fixed values of the command block
`ifndef OVL_CMD_MAP_SVH
`define OVL_CMD_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define REG_CTRL      4'h0
`define REG_STATUS    4'h4
`define REG_XPOS      4'h8
`define REG_ANCHOR    4'hc
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTRL_HEX      0
`define CTRL_ERR_EN   1
`define CTRL_EMU40    2
`define CTRL_RST      3'h0
// ---------------------------------------------------------------
// error codes
// ---------------------------------------------------------------
`define ERR_NONE      4'h0
`define ERR_RANGE     4'h1
`define ERR_INTEGER   4'h2
`define ERR_MEMORY    4'h3
`define ERR_OVERFLOW  4'h4
`define ERR_DIGIT     4'h5
`define ERR_OPCODE    4'h6
`define ERR_RUNNING   4'h7
`define ERR_STACK     4'h8
`define ERR_TOO_LONG  4'h9
`define ERR_AREA      4'ha
`define ERR_MISSING   4'hb
// ---------------------------------------------------------------
// fixed values
// ---------------------------------------------------------------
`define XH_FIXED      16'h0064
`define XH_FLAG_MAX   8'h04
`define RB_FLAG_MAX   8'h02
`define CHAR_CR       8'h0d
`define CHAR_COMMA    8'h2c
`define CHAR_ZERO     8'h30
`define DIGITS_LAST   3'h4
`define RB_HEX_BYTES  3'h4
`define STR_END       4'h8
`endif

// ==== verilog/ovl_cmd_pkg.sv ====
// types shared by the command block
`default_nettype none
package ovl_cmd_pkg;
  typedef enum logic [3:0] {
    overlay_position_cmd, overlay_visibility_cmd, overlay_colour_cmd,
    full_screen_select_cmd, crosshair_enable_cmd, crosshair_move_cmd,
    rubber_band_cmd, readback_cmd, other_cmd, unknown_cmd
  } op_e;
  typedef enum logic [1:0] {shp_line, shp_rect, shp_cross} shape_e;
  typedef enum logic [1:0] {st_idle, st_err, st_rb, st_draw} st_e;
endpackage
`default_nettype wire

// ==== verif/host_model.sv ====
// host side model: readback and error fifo sinks, drawing engine
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // fifo write ports
  input  wire logic       rb_wr,
  input  wire logic [7:0] rb_data,
  output logic            rb_full,
  input  wire logic       err_wr,
  input  wire logic [7:0] err_data,
  output logic            err_full,
  // drawing engine handshake
  input  wire logic       draw_valid,
  output logic            draw_ready
);
  logic [7:0] rb_q[$];
  logic [7:0] err_q[$];
  logic [3:0] tick;
  logic       stall = 1'b1;
  // free running count shapes the stalls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) tick <= 4'h0;
    else tick <= tick + 4'h1;
  end
  // host drains slowly: fifos look full part of the time
  assign rb_full    = stall & tick[3];
  assign err_full   = stall & tick[2];
  assign draw_ready = draw_valid & tick[0];
  // each write pulse lands one byte
  always @(posedge core_clk) begin
    if (rb_wr) rb_q.push_back(rb_data);
    if (err_wr) err_q.push_back(err_data);
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the overlay and cursor command block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ovl_cmd_pkg::*;
  logic        core_clk, rst_n, reg_wr, reg_rd, cmd_valid, cmd_ready;
  logic [3:0]  reg_addr, cmd_err;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [2:0]  cmd_nparam;
  logic [15:0] p[0:5];
  logic [15:0] x, y, r;
  op_e         cmd_op;
  shape_e      draw_shape, last_shape;
  logic [7:0]  shapes;
  logic        rb_full, rb_wr, err_full, err_wr, draw_valid, draw_ready;
  logic [7:0]  rb_data, err_data, gfx_pixel, emu_pixel, monitor_pixel;
  logic [4:0]  vid;
  logic [15:0] ovl_col, ovl_row;
  int          miscompares, checked, ndraw;
  overlay_readback_error_cursor_cmds i_dut (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_nparam(cmd_nparam), .cmd_err(cmd_err), .cmd_p0(p[0]),
    .cmd_p1(p[1]), .cmd_p2(p[2]), .cmd_p3(p[3]), .cmd_p4(p[4]),
    .cmd_p5(p[5]), .rb_full(rb_full), .rb_wr(rb_wr), .rb_data(rb_data),
    .err_full(err_full), .err_wr(err_wr), .err_data(err_data),
    .draw_valid(draw_valid), .draw_ready(draw_ready),
    .draw_shape(draw_shape), .draw_x0(), .draw_y0(), .draw_x1(),
    .draw_y1(), .draw_clip_view(), .ovl_x0(), .ovl_x1(), .ovl_y0(),
    .ovl_y1(), .ovl_col(ovl_col), .ovl_row(ovl_row),
    .gfx_pixel(gfx_pixel), .emu_pixel(emu_pixel), .in_window(vid[4]),
    .glyph_bit(vid[3]), .blink_attr(vid[2]), .blink_phase(vid[1]),
    .cursor_here(vid[0]), .monitor_pixel(monitor_pixel));
  host_model i_host (.core_clk(core_clk), .rst_n(rst_n), .rb_wr(rb_wr),
    .rb_data(rb_data), .rb_full(rb_full), .err_wr(err_wr),
    .err_data(err_data), .err_full(err_full), .draw_valid(draw_valid),
    .draw_ready(draw_ready));
  // clock of 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // count accepted draw requests
  always @(posedge core_clk) begin
    if (draw_valid && draw_ready) begin
      ndraw++;
      last_shape = draw_shape;
      shapes = {shapes[5:0], draw_shape};
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_str(input string s);
    chk(i_host.err_q.size(), s.len());
    foreach (i_host.err_q[i]) chk(i_host.err_q[i], s[i]);
    i_host.err_q.delete();
  endtask
  task automatic chk_code(input logic [7:0] b);
    chk(i_host.err_q.size(), 1);
    chk(i_host.err_q[0], b);
    i_host.err_q.delete();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    rv = reg_rdata;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 400; i++) begin
      @(negedge core_clk);
      if (cmd_ready === 1'b1) return;
    end
    miscompares++;
    tally_and_finish();
  endtask
  task automatic cmd(input op_e o, input logic [2:0] n,
                     input logic [3:0] e, input logic [15:0] a, b);
    @(posedge core_clk);
    cmd_op     <= o;
    cmd_nparam <= n;
    cmd_err    <= e;
    p[0]       <= a;
    p[1]       <= b;
    cmd_valid  <= 1'b1;
    wait_ready();
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    wait_ready();
    repeat (2) @(posedge core_clk);
  endtask
  task automatic pix(input logic [4:0] v, input logic [7:0] e);
    @(posedge core_clk);
    vid <= v;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(monitor_pixel, e);
  endtask
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, cmd_valid, reg_addr, reg_wdata, cmd_err} = 0;
    {cmd_nparam, x, y, vid, ndraw, miscompares, checked} = 0;
    foreach (p[i]) p[i] = 16'h0000;
    cmd_op = other_cmd;
    gfx_pixel = 8'h11;
    emu_pixel = 8'h22;
    r = 16'h0008;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(4'h0);
    chk(rv, 32'h0);
    rd(4'h2);
    chk(rv, 32'h0);
    wr(4'h0, 32'h2);
    cmd(unknown_cmd, 3'h1, 4'h0, 16'h0, 16'h0);
    chk_str("Opcode\015");
    cmd(crosshair_enable_cmd, 3'h1, 4'h0, 16'h5, 16'h0);
    chk_str("Range\015");
    cmd(crosshair_move_cmd, 3'h1, 4'h0, 16'h1, 16'h0);
    chk_str("Missing\015");
    wr(4'h0, 32'h0);
    cmd(unknown_cmd, 3'h1, 4'h0, 16'h0, 16'h0);
    chk_str("");
    wr(4'h0, 32'h3);
    for (int c = 1; c < 12; c++) begin
      cmd(other_cmd, 3'h1, c[3:0], 16'h0, 16'h0);
      if (c == 2 || c == 5 || c == 11) chk_str("");
      else chk_code(c[7:0]);
    end
    cmd(crosshair_enable_cmd, 3'h1, 4'h0, 16'h0, 16'h0);
    r = lfsr(r);
    x = r & 16'h01ff;
    r = lfsr(r);
    y = r & 16'h00ff;
    cmd(crosshair_move_cmd, 3'h2, 4'h0, x, y);
    rd(4'h8);
    chk(rv, {y, x});
    cmd(readback_cmd, 3'h1, 4'h0, 16'h0, 16'h0);
    chk(i_host.rb_q.size(), 4);
    chk({i_host.rb_q[0], i_host.rb_q[1], i_host.rb_q[2], i_host.rb_q[3]},
        {x, y});
    i_host.rb_q.delete();
    cmd(rubber_band_cmd, 3'h1, 4'h0, 16'h1, 16'h0);
    cmd(crosshair_move_cmd, 3'h2, 4'h0, 16'd500, 16'd400);
    rd(4'hc);
    chk(rv, {y, x});
    chk(ndraw, 1);
    cmd(crosshair_move_cmd, 3'h2, 4'h0, 16'd500, 16'd50);
    chk(ndraw, 3);
    cmd(rubber_band_cmd, 3'h1, 4'h0, 16'h2, 16'h0);
    chk(ndraw, 4);
    cmd(crosshair_move_cmd, 3'h2, 4'h0, 16'd20, 16'd30);
    chk(last_shape, shp_rect);
    cmd(rubber_band_cmd, 3'h1, 4'h0, 16'h0, 16'h0);
    chk(ndraw, 6);
    cmd(rubber_band_cmd, 3'h1, 4'h0, 16'h1, 16'h0);
    cmd(crosshair_enable_cmd, 3'h1, 4'h0, 16'h2, 16'h0);
    cmd(crosshair_move_cmd, 3'h2, 4'h0, 16'd40, 16'd60);
    chk(ndraw, 10);
    chk(shapes, {shp_cross, shp_cross, shp_line, shp_cross});
    wr(4'h0, 32'h4);
    p[4] <= 16'd20;
    p[5] <= 16'd4;
    cmd(overlay_position_cmd, 3'h6, 4'h0, 16'd512, 16'd527);
    chk({ovl_col, ovl_row}, {16'd20, 16'd8});
    cmd(overlay_visibility_cmd, 3'h1, 4'h0, 16'h1, 16'h0);
    pix(5'b11000, 8'h0f);
    pix(5'b10000, 8'h11);
    pix(5'b11110, 8'h11);
    pix(5'b10001, 8'h0f);
    cmd(overlay_colour_cmd, 3'h3, 4'h0, 16'h005a, 16'h0);
    pix(5'b11000, 8'h5a);
    cmd(overlay_visibility_cmd, 3'h1, 4'h0, 16'h0, 16'h0);
    pix(5'b11000, 8'h11);
    cmd(full_screen_select_cmd, 3'h1, 4'h0, 16'h1, 16'h0);
    pix(5'b00000, 8'h22);
    tally_and_finish();
  end
endmodule
`default_nettype wire
